// ===== logic/apc_seq.sv
// parallel-port control and conversion sequencing for a six-channel converter
`timescale 1ns/10ps
module apc_seq #(
	parameter int INT_DIV = apc_pkg::INT_DIV
) (
	// system
	input  wire logic                          I_CLK,
	input  wire logic                          I_RST,
	// host parallel port
	input  wire logic                          I_CS_N,
	input  wire logic                          I_WR_N,
	input  wire logic                          I_RD_N,
	input  wire logic [7:0]                    I_BUS_LINES,
	output logic      [apc_pkg::RESULT_W-1:0]  O_BUS_LINES,
	output logic                               O_BUS_LINES_OE_N,
	output logic                               O_DONE_N,
	// external conversion clock pin
	input  wire logic                          I_CONV_CLK,
	// analog front end
	input  wire logic                          I_CMP_ABOVE,
	output logic      [apc_pkg::RESULT_W-1:0]  O_DAC_CODE,
	output logic                               O_TRACK,
	output logic      [2:0]                    O_MUX_SEL,
	output logic                               O_SPAN_SELECT,
	output logic                               O_SIGNED_INPUT_SELECT,
	output logic                               O_STANDBY_SLEEP,
	output logic                               O_DEEP_SLEEP,
	output logic                               O_INT_CLK_SEL
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [2:0]                   cs_sync;
		logic [2:0]                   wr_sync;
		logic [2:0]                   rd_sync;
		logic [2:0]                   ck_sync;
		logic                         cs_n;
		logic                         wr_n;
		logic                         rd_n;
		logic                         ck;
		logic [7:0]                   bus_hold;
		apc_pkg::apc_ctrl_t           ctrl;
		logic                         int_clk;
		logic [1:0]                   pd_pending;
		logic [1:0]                   pd_active;
		apc_pkg::apc_state_t          state;
		logic [3:0]                   count;
		logic                         done_n;
		logic                         oe_n;
		logic [apc_pkg::RESULT_W-1:0] data_out;
		logic [7:0]                   div_cnt;
		logic                         sar_start;
		logic                         sar_step;
	} apc_state_reg_t;

	apc_state_reg_t s_reg;
	apc_state_reg_t s_next;
	logic [apc_pkg::RESULT_W-1:0] sar_trial;
	logic [apc_pkg::RESULT_W-1:0] sar_result;

	apc_sar #(
		.WIDTH     (apc_pkg::RESULT_W)
	) u_sar (
		.clk       (I_CLK),
		.rst       (I_RST),
		.start     (s_reg.sar_start),
		.step      (s_reg.sar_step),
		.cmp_above (I_CMP_ABOVE),
		.trial     (sar_trial),
		.result    (sar_result)
	);

	////////////////////////////////////////////////////////////////////////
	logic                   wr_rise;
	logic                   wr_fall;
	logic                   rd_fall;
	logic                   ext_tick;
	logic                   int_tick;
	logic                   tick;
	logic                   read_active;
	logic [7:0]             byte_in;
	logic                   new_int_clk;

	always_comb begin
		// a change counts once the second and third stages agree
		wr_rise = s_reg.wr_sync[1] & s_reg.wr_sync[2] & ~s_reg.wr_n;
		wr_fall = ~s_reg.wr_sync[1] & ~s_reg.wr_sync[2] & s_reg.wr_n;
		rd_fall = ~s_reg.rd_sync[1] & ~s_reg.rd_sync[2] & s_reg.rd_n;
		ext_tick = s_reg.ck_sync[1] & s_reg.ck_sync[2] & ~s_reg.ck;
		int_tick = (s_reg.div_cnt == 8'(INT_DIV - 1));
		tick = s_reg.int_clk ? int_tick : ext_tick;
		read_active = ~s_reg.cs_n & ~s_reg.rd_n;
		byte_in = s_reg.bus_hold;
		new_int_clk = s_reg.int_clk;
		if (byte_in[apc_pkg::POWER_MODE_HI_BIT] == 1'b0) begin
			new_int_clk = byte_in[apc_pkg::POWER_MODE_LO_BIT];
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.sar_start = 1'b0;
		s_next.sar_step  = 1'b0;
		s_next.cs_sync = {s_reg.cs_sync[1:0], I_CS_N};
		s_next.wr_sync = {s_reg.wr_sync[1:0], I_WR_N};
		s_next.rd_sync = {s_reg.rd_sync[1:0], I_RD_N};
		s_next.ck_sync = {s_reg.ck_sync[1:0], I_CONV_CLK};
		if (s_reg.cs_sync[1] == s_reg.cs_sync[2]) begin
			s_next.cs_n = s_reg.cs_sync[2];
		end
		if (s_reg.wr_sync[1] == s_reg.wr_sync[2]) begin
			s_next.wr_n = s_reg.wr_sync[2];
		end
		if (s_reg.rd_sync[1] == s_reg.rd_sync[2]) begin
			s_next.rd_n = s_reg.rd_sync[2];
		end
		if (s_reg.ck_sync[1] == s_reg.ck_sync[2]) begin
			s_next.ck = s_reg.ck_sync[2];
		end
		// bus lines are stable while the write strobe is low
		if (~s_reg.cs_n & ~s_reg.wr_n) begin
			s_next.bus_hold = I_BUS_LINES;
		end
		s_next.div_cnt = int_tick ? 8'h00 : s_reg.div_cnt + 8'h01;

		// wake on write falling edge
		if (wr_fall & ~s_reg.cs_n) begin
			s_next.pd_active  = 2'h0;
			s_next.pd_pending = 2'h0;
		end

		// conversion sequencing
		case (s_reg.state)
			apc_pkg::ST_ACQ_TIMED: begin
				if (tick) begin
					if (s_reg.count == 4'(apc_pkg::ACQ_CYCLES - 1)) begin
						s_next.state = apc_pkg::ST_CONVERT;
						s_next.count = 4'h0;
						s_next.sar_start = 1'b1;
					end else begin
						s_next.count = s_reg.count + 4'h1;
					end
				end
			end
			apc_pkg::ST_CONVERT: begin
				// the dac register lags the sar by a cycle, so a tick right
				// after a start would weigh the old trial; let that one pass
				if (tick && !s_reg.sar_start) begin
					s_next.sar_step = 1'b1;
					if (s_reg.count == 4'(apc_pkg::CONV_CYCLES - 1)) begin
						s_next.state = apc_pkg::ST_IDLE;
						s_next.done_n = 1'b0;
						s_next.pd_active = s_reg.pd_pending;
					end else begin
						s_next.count = s_reg.count + 4'h1;
					end
				end
			end
			default: begin
			end
		endcase

		// latch the last bit into the result once the step lands
		if (s_reg.state == apc_pkg::ST_IDLE && s_reg.done_n == 1'b0 && !read_active) begin
			s_next.data_out = sar_result;
			// sar yields offset binary; bipolar flips the top bit to twos complement
			if (s_reg.ctrl.signed_input_select) begin
				s_next.data_out[apc_pkg::RESULT_W-1] = ~sar_result[apc_pkg::RESULT_W-1];
			end
		end

		// read clears completion flag; a finish in the same cycle wins
		if (rd_fall & ~s_reg.cs_n & s_reg.done_n == 1'b0 & s_next.done_n == 1'b0
			& s_reg.state != apc_pkg::ST_CONVERT) begin
			s_next.done_n = 1'b1;
		end

		// write rising edge takes the control byte
		if (wr_rise & ~s_reg.cs_n) begin
			s_next.ctrl     = apc_pkg::apc_ctrl_t'(byte_in);
			s_next.int_clk  = new_int_clk;
			s_next.done_n   = 1'b1;
			s_next.count    = 4'h0;
			s_next.pd_pending = byte_in[apc_pkg::POWER_MODE_HI_BIT]
				? byte_in[7:6] : apc_pkg::PM_NORMAL_EXT;
			if (byte_in[apc_pkg::SAMPLE_WINDOW_SELECT_BIT]) begin
				s_next.state = apc_pkg::ST_ACQ_OPEN;
			end else if (s_reg.state == apc_pkg::ST_ACQ_OPEN) begin
				s_next.state = apc_pkg::ST_CONVERT;
				s_next.sar_start = 1'b1;
			end else begin
				s_next.state = apc_pkg::ST_ACQ_TIMED;
			end
		end

		// drive the port only while chip select and read are low
		s_next.oe_n = ~(~s_next.cs_n & ~s_next.rd_n);
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			s_reg          <= '0;
			s_reg.cs_sync  <= 3'h7;
			s_reg.wr_sync  <= 3'h7;
			s_reg.rd_sync  <= 3'h7;
			s_reg.cs_n     <= 1'b1;
			s_reg.wr_n     <= 1'b1;
			s_reg.rd_n     <= 1'b1;
			s_reg.ctrl     <= apc_pkg::apc_ctrl_t'(apc_pkg::CONTROL_RESET);
			s_reg.int_clk  <= 1'b0;
			s_reg.state    <= apc_pkg::ST_IDLE;
			s_reg.done_n   <= 1'b1;
			s_reg.oe_n     <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output registers; every pin comes straight from a flop
	logic [apc_pkg::RESULT_W-1:0] dac_reg;
	logic                         track_reg;
	logic                         stby_reg;
	logic                         deep_reg;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			dac_reg   <= '0;
			track_reg <= 1'b0;
			stby_reg  <= 1'b0;
			deep_reg  <= 1'b0;
		end else begin
			dac_reg   <= sar_trial;
			track_reg <= (s_reg.state == apc_pkg::ST_ACQ_TIMED)
				|| (s_reg.state == apc_pkg::ST_ACQ_OPEN);
			// decoded from the next state so sleep flags keep their old timing
			stby_reg  <= (s_next.pd_active == apc_pkg::PM_STANDBY);
			deep_reg  <= (s_next.pd_active == apc_pkg::PM_DEEP);
		end
	end

	// coding is settled when the result is latched, so the port is a plain flop
	assign O_BUS_LINES = s_reg.data_out;
	assign O_BUS_LINES_OE_N      = s_reg.oe_n;
	assign O_DONE_N              = s_reg.done_n;
	assign O_DAC_CODE            = dac_reg;
	assign O_TRACK               = track_reg;
	assign O_MUX_SEL             = s_reg.ctrl.mux_sel;
	assign O_SPAN_SELECT         = s_reg.ctrl.span_select;
	assign O_SIGNED_INPUT_SELECT = s_reg.ctrl.signed_input_select;
	assign O_STANDBY_SLEEP       = stby_reg;
	assign O_DEEP_SLEEP          = deep_reg;
	assign O_INT_CLK_SEL         = s_reg.int_clk;
endmodule // apc_seq

// ===== logic/apc_pkg.sv
// shared constants and types for the converter sequencer
package apc_pkg;
	// control byte field positions
	localparam int POWER_MODE_HI_BIT        = 7;
	localparam int POWER_MODE_LO_BIT        = 6;
	localparam int SAMPLE_WINDOW_SELECT_BIT = 5;
	localparam int SPAN_SELECT_BIT          = 4;
	localparam int SIGNED_INPUT_SELECT_BIT  = 3;
	localparam int MUX_SEL_MSB              = 2;
	// power mode codes
	localparam logic [1:0] PM_NORMAL_EXT = 2'h0;
	localparam logic [1:0] PM_NORMAL_INT = 2'h1;
	localparam logic [1:0] PM_STANDBY    = 2'h2;
	localparam logic [1:0] PM_DEEP       = 2'h3;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// timing counts in conversion-clock cycles
	localparam int ACQ_CYCLES  = 6;
	localparam int CONV_CYCLES = 12;
	// internal clock divider: 10 MHz divided by 7, down to about 1.43 MHz
	localparam int CLK_HZ      = 10000000;
	localparam int INT_CLK_HZ  = 1560000;
	localparam int INT_DIV     = (CLK_HZ + INT_CLK_HZ - 1) / INT_CLK_HZ;
	localparam int RESULT_W    = 12;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACQ_TIMED,
		ST_ACQ_OPEN,
		ST_CONVERT
	} apc_state_t;

	typedef struct packed {
		logic [1:0] power_mode;
		logic       sample_window_select;
		logic       span_select;
		logic       signed_input_select;
		logic [2:0] mux_sel;
	} apc_ctrl_t;
endpackage

// ===== logic/apc_sar.sv
// successive-approximation register, one bit per conversion step
`timescale 1ns/10ps
module apc_sar #(
	parameter int WIDTH = 12
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic             step,
	input  wire logic             cmp_above,
	output logic [WIDTH-1:0]      trial,
	output logic [WIDTH-1:0]      result
);
	typedef struct packed {
		logic [WIDTH-1:0] code;
		logic [WIDTH-1:0] probe;
	} apc_sar_t;

	apc_sar_t s_reg;
	apc_sar_t s_next;

	always_comb begin
		s_next = s_reg;
		if (start) begin
			s_next.code  = '0;
			s_next.probe = {1'b1, {(WIDTH-1){1'b0}}};
		end else if (step && (s_reg.probe != '0)) begin
			// keep the probed bit when the input is at or above the trial level
			if (cmp_above) begin
				s_next.code = s_reg.code | s_reg.probe;
			end
			s_next.probe = s_reg.probe >> 1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign trial  = s_reg.code | s_reg.probe;
	assign result = s_reg.code;
endmodule // apc_sar

// ===== tb/apc_monitor.sv
// port checks for the converter sequencer
`timescale 1ns/10ps
module apc_monitor (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic O_BUS_LINES_OE_N,
	input wire logic O_DONE_N,
	input wire logic O_TRACK,
	input wire logic O_STANDBY_SLEEP,
	input wire logic O_DEEP_SLEEP,
	input wire logic O_INT_CLK_SEL
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	wire logic sleep = O_STANDBY_SLEEP | O_DEEP_SLEEP;
	// six idle cycles outlast the input sync
	property p_cs_idle; I_CS_N [*6] |-> O_BUS_LINES_OE_N; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("bus driven, cs high");
	property p_rd_idle; I_RD_N [*6] |-> O_BUS_LINES_OE_N; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("bus driven, rd high");
	property p_rd_clear; $fell(O_BUS_LINES_OE_N) |-> ##[0:4] O_DONE_N; endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("done kept on read");
	property p_conv_len; $fell(O_TRACK) |-> O_DONE_N [*8]; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too short");
	property p_done_hold; $fell(O_DONE_N) |-> !O_TRACK; endproperty
	a_done_hold: assert property (p_done_hold) else $error("done while tracking");
	property p_reset;
		$fell(I_RST) |-> O_DONE_N && O_BUS_LINES_OE_N && !O_INT_CLK_SEL;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_awake; O_TRACK |-> !sleep; endproperty
	a_awake: assert property (p_awake) else $error("asleep while tracking");
	property p_sleep_end; $rose(sleep) |-> ##[0:2] !O_DONE_N; endproperty
	a_sleep_end: assert property (p_sleep_end) else $error("sleep before end");
	property p_clk_kept; $rose(sleep) |-> $stable(O_INT_CLK_SEL); endproperty
	a_clk_kept: assert property (p_clk_kept) else $error("clock source moved");
	c_done: cover property ($fell(O_DONE_N));
	c_read: cover property ($fell(O_BUS_LINES_OE_N));
	c_sleep: cover property ($rose(O_DEEP_SLEEP));
endmodule // apc_monitor

// ===== tb/apc_far_model.sv
// conversion clock source and comparator of the analog side
`timescale 1ns/10ps
module apc_far_model (
	input  wire logic [11:0] dac_code,
	input  wire logic [11:0] level,
	output logic             conv_clk,
	output logic             cmp_above
);
	// 2 MHz even duty, top of the allowed band
	initial conv_clk = 1'b0;
	always #250 conv_clk = ~conv_clk;
	assign cmp_above = (level >= dac_code);
endmodule // apc_far_model

// ===== tb/apc_seq_test.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module apc_seq_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cs_n = 1'b1;
	logic        wr_n = 1'b1;
	logic        rd_n = 1'b1;
	logic [7:0]  bus_in = 8'h00;
	logic [11:0] level = 12'h000;
	logic [11:0] bus_out, dac;
	logic        oe_n, done_n, cclk, cmp, track, span, sgn, stby, deep, intc;
	logic [2:0]  mux;
	int          n_errors = 0;
	int          total_checks = 0;

	always #50 clk = ~clk;

	apc_seq #(.INT_DIV(7)) u_apc_seq (.I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n),
		.I_WR_N(wr_n), .I_RD_N(rd_n), .I_BUS_LINES(bus_in), .O_BUS_LINES(bus_out),
		.O_BUS_LINES_OE_N(oe_n), .O_DONE_N(done_n), .I_CONV_CLK(cclk),
		.I_CMP_ABOVE(cmp), .O_DAC_CODE(dac), .O_TRACK(track), .O_MUX_SEL(mux),
		.O_SPAN_SELECT(span), .O_SIGNED_INPUT_SELECT(sgn), .O_STANDBY_SLEEP(stby),
		.O_DEEP_SLEEP(deep), .O_INT_CLK_SEL(intc));
	apc_far_model u_apc_far_model (.dac_code(dac), .level(level), .conv_clk(cclk),
		.cmp_above(cmp));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] s, input logic [11:0] e, input string nm);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic chkb(input logic s, input logic e, input string nm);
		chk({11'h0, s}, {11'h0, e}, nm);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// five cycles a phase so the three-flop sync sees each one
	task automatic wr(input logic [7:0] b, input logic sel_n);
		cs_n = sel_n;
		bus_in = b;
		cyc(5);
		wr_n = 1'b0;
		cyc(5);
		wr_n = 1'b1;
		cyc(5);
		cs_n = 1'b1;
		bus_in = ~b; // released lines do not hold their value
		cyc(5);
	endtask
	task automatic rd(input logic [11:0] e);
		int k;
		cs_n = 1'b0;
		cyc(2);
		rd_n = 1'b0;
		for (k = 0; k < 20 && oe_n !== 1'b0; k++) cyc(1);
		cyc(1);
		chkb(oe_n, 1'b0, "drive");
		chk(bus_out, e, "result");
		chkb(done_n, 1'b1, "done on read");
		rd_n = 1'b1;
		cyc(3);
		cs_n = 1'b1;
		cyc(6);
		chkb(oe_n, 1'b1, "released");
	endtask
	task automatic wait_done();
		int k;
		for (k = 0; k < 400 && done_n !== 1'b0; k++) cyc(1);
		chkb(done_n, 1'b0, "done");
		chkb(track, 1'b0, "hold");
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [7:0] b;
		cyc(20);
		rst = 1'b0;
		cyc(1);
		chkb(done_n, 1'b1, "done at reset");
		chkb(intc, 1'b0, "clock at reset");
		for (i = 0; i < 6; i++) begin
			b = {3'b000, i[1:0], i[2:0]}; // channel codes 0..5 only
			level = 12'h1A5 + 12'h2D3 * i[11:0];
			wr(b, 1'b0);
			chk({9'h0, mux}, {9'h0, b[2:0]}, "channel");
			chkb(span, b[4], "span");
			chkb(sgn, b[3], "signed");
			chkb(track, 1'b1, "tracking");
			wr(8'hFF, 1'b1);
			chk({9'h0, mux}, {9'h0, b[2:0]}, "ignored");
			wait_done();
			rd(level ^ {b[3], 11'h000});
			chk(dac, level, "trial code");
		end
		level = 12'hC3E;
		wr(8'h62, 1'b0);
		chkb(intc, 1'b1, "internal clock");
		cyc(300);
		chkb(track, 1'b1, "open window");
		chkb(done_n, 1'b1, "no result");
		wr(8'h62, 1'b0); // same channel bits
		chkb(track, 1'b1, "restarted");
		wr(8'h42, 1'b0); // same channel bits
		chkb(track, 1'b0, "converting");
		wait_done();
		rd(12'hC3E);
		wr(8'h40, 1'b0);
		for (i = 0; i < 200 && track !== 1'b0; i++) cyc(1);
		cyc(20);
		wr(8'h41, 1'b0);
		chkb(track, 1'b1, "aborted");
		wait_done();
		rd(12'hC3E);
		wr(8'hC0, 1'b0);
		chkb(deep, 1'b0, "awake in run");
		wait_done();
		cyc(2);
		chkb(deep, 1'b1, "deep");
		chkb(intc, 1'b1, "clock kept");
		wr(8'h80, 1'b0);
		chkb(done_n, 1'b1, "done on write");
		chkb(deep, 1'b0, "woken");
		wait_done();
		cyc(2);
		chkb(stby, 1'b1, "standby");
		rd(12'hC3E);
		wr(8'h00, 1'b0);
		chkb(intc, 1'b0, "external clock");
		wait_done();
		rd(12'hC3E);
		complete_run();
	end

	// whole run is a few thousand cycles
	initial begin
		#(100 * 30000);
		n_errors++;
		complete_run();
	end
endmodule // apc_seq_test

bind apc_seq apc_monitor u_apc_monitor (.I_CLK, .I_RST, .I_CS_N, .I_RD_N,
	.O_BUS_LINES_OE_N, .O_DONE_N, .O_TRACK, .O_STANDBY_SLEEP, .O_DEEP_SLEEP,
	.O_INT_CLK_SEL);
